/* File: src/drive_pds_regs.vh */
// Constants of the drive power state machine: register indices, fields, codes.
// Assumes inclusion by the single design file; definitions only.
`ifndef DRIVE_POWER_STATE_REGS_VH
`define DRIVE_POWER_STATE_REGS_VH

// Register indices; byte address is four times the index
`define IDX_COMMAND_WORD 16'h6040
`define IDX_STATE_WORD 16'h6041
`define IDX_MODE_SELECT 16'h6060
`define IDX_MODE_DISPLAY 16'h6061
`define IDX_SUPPORTED_MODES 16'h6502
`define IDX_UNDERVOLT_SELECT 16'h3508
`define IDX_ERROR_STATUS 16'h3FF0
`define ADDR_WIDTH 18
`define INDEX_WIDTH 16

// Command word bit positions
`define CW_VOLTAGE_ON 0
`define CW_POWER_ENABLE 1
`define CW_HALT_REQUEST 2
`define CW_RUN_ENABLE 3
`define CW_ERROR_CLEAR 7

// State word bit positions
`define SW_READY 0
`define SW_SWITCHED_ON 1
`define SW_RUN_ENABLED 2
`define SW_FAULT 3
`define SW_VOLTAGE 4
`define SW_HALT 5
`define SW_ON_DISABLED 6
`define SW_WARNING 7

// Operation mode codes
`define MODE_PROFILE_POINT 8'h01
`define MODE_ORIGIN_SEARCH 8'h06
`define MODE_CYCLIC_POSITION 8'h08
`define MODE_CYCLIC_VELOCITY 8'h09
`define MODE_CYCLIC_TORQUE 8'h0A
`define MODE_RESET 8'h00

// Supported mode list bit positions
`define SUP_PROFILE_POINT 0
`define SUP_ORIGIN_SEARCH 5
`define SUP_CYCLIC_POSITION 7
`define SUP_CYCLIC_VELOCITY 8
`define SUP_CYCLIC_TORQUE 9

// Hardware revisions that unlock modes, major/minor in nibbles
`define REV_CYCLIC_EXTRA 8'h20
`define REV_PROFILE_POINT 8'h21
`define REV_DEFAULT 8'h21

`endif

/* File: src/drive_power_state_machine.v */
// Drive power state machine with APB register access and operation mode handling.
// Assumes a single APB master on pclk; status inputs come from other domains.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "drive_pds_regs.vh"

// Operation
// R01: Power state changes only via command word or internal events.
// R02: Decode bits 0-3: shutdown x110, switch on 0111, enable 1111, bit1 clear disables.
// R03: Enable pattern from ready passes switched-on then enters operation enabled.
// R04: Halt request (bit2 clear, bit1 set) ignored; state unchanged.
// R05: Bit 7 rising in fault clears errors and returns to switch-on disabled.
// R06: Bit 7 rising clears warning; outside fault commands act as usual.
// R07: Host clears bit 7 again before its next command.
// R08: State bits 6,5,3,2,1,0: not ready, disabled, ready, switched on codes.
// R09: Operation enabled 010111, fault reaction 011111, fault 011000.
// R10: Not ready during init, then switch-on disabled; writes accepted always.
// R11: Main power in switched-on, servo energized only when operation enabled.
// R12: Power loss with servo on and select zero: go ready, shutdown stop.
// R13: Power loss with servo on and select one: fault reaction, fault stop.
// R14: Mode taken from mode select, mode in effect mirrored in display.
// R15: Read-only list of supported modes.
// R16: Unsupported mode write raises the function setting error.
// R17: Cyclic velocity, cyclic torque, origin search need revision 2.0 or later.
// R18: Profile point mode needs revision 2.1 or later.
// R19: Internal error enters fault reaction, then fault once reaction completes; ignored here while not ready.
// R20: Pattern with no valid transition leaves the state unchanged.
module drive_power_state_machine #(
  parameter [7:0] hw_revision = `REV_DEFAULT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire main_power_ok,
  input wire init_done,
  input wire internal_error,
  input wire reaction_done,
  input wire warning_in,
  output reg main_power_on,
  output reg servo_on,
  output reg stop_by_shutdown_option,
  output reg stop_by_fault_option,
  output reg setting_error
);

  localparam [2:0] st_not_ready = 3'd0;
  localparam [2:0] st_on_disabled = 3'd1;
  localparam [2:0] st_ready = 3'd2;
  localparam [2:0] st_switched_on = 3'd3;
  localparam [2:0] st_run_enabled = 3'd4;
  localparam [2:0] st_fault_reaction = 3'd5;
  localparam [2:0] st_fault = 3'd6;
  localparam integer n_sync = 5;

  // Pin synchronisers; stage one is read only by stage two
  wire [n_sync-1:0] raw_in;
  reg [n_sync-1:0] sync_a;
  reg [n_sync-1:0] sync_b;
  assign raw_in = {warning_in, reaction_done, internal_error, init_done, main_power_ok};

  genvar gi;
  generate
    for (gi = 0; gi < n_sync; gi = gi + 1)
    begin : g_sync
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire power_ok_s = sync_b[0];
  wire init_done_s = sync_b[1];
  wire int_error_s = sync_b[2];
  wire reaction_done_s = sync_b[3];
  wire warning_s = sync_b[4];

  reg [2:0] drive_power_state;
  reg [2:0] next_drive_power_state;
  reg [15:0] drive_command_word;
  reg error_clear_prev;
  reg [7:0] operation_mode_select;
  reg [7:0] operation_mode_display;
  reg undervolt_select;
  reg warning_flag;
  reg int_error_latched;
  reg power_loss_latched;

  // APB decode
  wire [`INDEX_WIDTH-1:0] reg_index = paddr[`ADDR_WIDTH-1:2];
  wire setup_phase = psel & ~penable;
  wire write_done = psel & penable & pready & pwrite & ~pslverr;
  wire hit_cmd = (reg_index == `IDX_COMMAND_WORD);
  wire hit_state = (reg_index == `IDX_STATE_WORD);
  wire hit_msel = (reg_index == `IDX_MODE_SELECT);
  wire hit_mdisp = (reg_index == `IDX_MODE_DISPLAY);
  wire hit_sup = (reg_index == `IDX_SUPPORTED_MODES);
  wire hit_uv = (reg_index == `IDX_UNDERVOLT_SELECT);
  wire hit_err = (reg_index == `IDX_ERROR_STATUS);
  wire hit_rw = hit_cmd | hit_msel | hit_uv;
  wire hit_any = hit_rw | hit_state | hit_mdisp | hit_sup | hit_err;

  // Supported modes depend on revision; list is constant for a build
  wire rev_cyc = (hw_revision >= `REV_CYCLIC_EXTRA); // [R17]
  wire rev_profile = (hw_revision >= `REV_PROFILE_POINT); // [R18]
  reg [31:0] supported_mode_list;
  always @*
  begin
    supported_mode_list = 32'h0000_0000;
    supported_mode_list[`SUP_CYCLIC_POSITION] = 1'b1; // [R15]
    supported_mode_list[`SUP_CYCLIC_VELOCITY] = rev_cyc; // [R17]
    supported_mode_list[`SUP_CYCLIC_TORQUE] = rev_cyc; // [R17]
    supported_mode_list[`SUP_ORIGIN_SEARCH] = rev_cyc; // [R17]
    supported_mode_list[`SUP_PROFILE_POINT] = rev_profile; // [R18]
  end

  reg mode_ok;
  always @*
  begin
    case (pwdata[7:0])
      `MODE_CYCLIC_POSITION: mode_ok = 1'b1;
      `MODE_CYCLIC_VELOCITY: mode_ok = rev_cyc; // [R17]
      `MODE_CYCLIC_TORQUE: mode_ok = rev_cyc; // [R17]
      `MODE_ORIGIN_SEARCH: mode_ok = rev_cyc; // [R17]
      `MODE_PROFILE_POINT: mode_ok = rev_profile; // [R18]
      default: mode_ok = 1'b0;
    endcase
  end

  wire mode_write = write_done & hit_msel;
  wire bad_mode = mode_write & ~mode_ok; // [R16]

  // Command decode from the stored command word
  wire cw_switch = drive_command_word[`CW_VOLTAGE_ON];
  wire cw_power = drive_command_word[`CW_POWER_ENABLE];
  wire cw_halt = drive_command_word[`CW_HALT_REQUEST];
  wire cw_run = drive_command_word[`CW_RUN_ENABLE];
  wire cmd_disable = ~cw_power; // [R02]
  wire cmd_shutdown = cw_halt & cw_power & ~cw_switch; // [R02]
  wire cmd_switch_on = ~cw_run & cw_halt & cw_power & cw_switch; // [R02]
  wire cmd_enable = cw_run & cw_halt & cw_power & cw_switch; // [R02]
  wire error_clear_edge = drive_command_word[`CW_ERROR_CLEAR] & ~error_clear_prev; // [R05]
  wire servo_active = (drive_power_state == st_run_enabled);
  wire power_lost = servo_active & ~power_ok_s;
  wire error_event = int_error_s | bad_mode; // [R19]

  // Halt request patterns match no command below and so hold the state [R04]
  always @*
  begin
    next_drive_power_state = drive_power_state; // [R20]
    case (drive_power_state)
      st_not_ready:
        if (init_done_s)
          next_drive_power_state = st_on_disabled; // [R10]
      st_on_disabled:
        if (error_event)
          next_drive_power_state = st_fault_reaction; // [R19]
        else if (cmd_shutdown)
          next_drive_power_state = st_ready; // [R02]
      st_ready:
        if (error_event)
          next_drive_power_state = st_fault_reaction; // [R19]
        else if (cmd_disable)
          next_drive_power_state = st_on_disabled; // [R02]
        else if (cmd_switch_on | cmd_enable)
          next_drive_power_state = st_switched_on; // [R03]
      st_switched_on:
        if (error_event)
          next_drive_power_state = st_fault_reaction; // [R19]
        else if (cmd_disable)
          next_drive_power_state = st_on_disabled; // [R02]
        else if (cmd_shutdown)
          next_drive_power_state = st_ready; // [R02]
        else if (cmd_enable)
          next_drive_power_state = st_run_enabled; // [R03]
      st_run_enabled:
        if (error_event)
          next_drive_power_state = st_fault_reaction; // [R19]
        else if (power_lost & undervolt_select)
          next_drive_power_state = st_fault_reaction; // [R13]
        else if (power_lost)
          next_drive_power_state = st_ready; // [R12]
        else if (cmd_disable)
          next_drive_power_state = st_on_disabled; // [R02]
        else if (cmd_shutdown)
          next_drive_power_state = st_ready; // [R02]
        else if (cmd_switch_on)
          next_drive_power_state = st_switched_on; // [R02]
      st_fault_reaction:
        if (reaction_done_s)
          next_drive_power_state = st_fault; // [R19]
      st_fault:
        if (error_clear_edge)
          next_drive_power_state = st_on_disabled; // [R05]
      default:
        next_drive_power_state = st_not_ready;
    endcase
  end

  // State word assembly
  reg [15:0] drive_state_word;
  always @*
  begin
    drive_state_word = 16'h0000;
    case (drive_power_state)
      st_on_disabled:
      begin
        drive_state_word[`SW_ON_DISABLED] = 1'b1; // [R08]
        drive_state_word[`SW_HALT] = 1'b1;
      end
      st_ready:
      begin
        drive_state_word[`SW_HALT] = 1'b1; // [R08]
        drive_state_word[`SW_READY] = 1'b1;
      end
      st_switched_on:
      begin
        drive_state_word[`SW_HALT] = 1'b1; // [R08]
        drive_state_word[`SW_SWITCHED_ON] = 1'b1;
        drive_state_word[`SW_READY] = 1'b1;
      end
      st_run_enabled:
      begin
        drive_state_word[`SW_HALT] = 1'b1; // [R09]
        drive_state_word[`SW_RUN_ENABLED] = 1'b1;
        drive_state_word[`SW_SWITCHED_ON] = 1'b1;
        drive_state_word[`SW_READY] = 1'b1;
      end
      st_fault_reaction:
      begin
        drive_state_word[`SW_HALT] = 1'b1; // [R09]
        drive_state_word[`SW_FAULT] = 1'b1;
        drive_state_word[`SW_RUN_ENABLED] = 1'b1;
        drive_state_word[`SW_SWITCHED_ON] = 1'b1;
        drive_state_word[`SW_READY] = 1'b1;
      end
      st_fault:
      begin
        drive_state_word[`SW_HALT] = 1'b1; // [R09]
        drive_state_word[`SW_FAULT] = 1'b1;
      end
      default:
        drive_state_word = 16'h0000; // [R08]
    endcase
    drive_state_word[`SW_VOLTAGE] = power_ok_s;
    drive_state_word[`SW_WARNING] = warning_flag;
  end

  reg [31:0] read_mux;
  always @*
  begin
    read_mux = 32'h0000_0000;
    if (hit_cmd)
      read_mux[15:0] = drive_command_word;
    else if (hit_state)
      read_mux[15:0] = drive_state_word;
    else if (hit_msel)
      read_mux[7:0] = operation_mode_select;
    else if (hit_mdisp)
      read_mux[7:0] = operation_mode_display; // [R14]
    else if (hit_sup)
      read_mux = supported_mode_list; // [R15]
    else if (hit_uv)
      read_mux[0] = undervolt_select;
    else if (hit_err)
      read_mux[2:0] = {power_loss_latched, int_error_latched, setting_error};
  end

  // APB slave: answer registered in the setup cycle, so every access is two cycles
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata <= pwrite ? 32'h0000_0000 : read_mux;
      pready <= 1'b1;
      pslverr <= ~hit_any | (pwrite & ~hit_rw);
    end
    else
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Writable registers; the bus stays open in every state [R10]
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_command_word <= 16'h0000;
      error_clear_prev <= 1'b0;
      operation_mode_select <= `MODE_RESET;
      operation_mode_display <= `MODE_RESET;
      undervolt_select <= 1'b0;
    end
    else
    begin
      error_clear_prev <= drive_command_word[`CW_ERROR_CLEAR];
      if (write_done & hit_cmd)
        drive_command_word <= pwdata[15:0]; // [R01]
      if (write_done & hit_uv)
        undervolt_select <= pwdata[0];
      if (mode_write)
        operation_mode_select <= pwdata[7:0]; // [R14]
      if (mode_write & mode_ok)
        operation_mode_display <= pwdata[7:0]; // [R14]
    end
  end

  // State, flags and outputs; a new event wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_power_state <= st_not_ready; // [R10]
      warning_flag <= 1'b0;
      setting_error <= 1'b0;
      int_error_latched <= 1'b0;
      power_loss_latched <= 1'b0;
      main_power_on <= 1'b0;
      servo_on <= 1'b0;
      stop_by_shutdown_option <= 1'b0;
      stop_by_fault_option <= 1'b0;
    end
    else
    begin
      drive_power_state <= next_drive_power_state;
      if (warning_s)
        warning_flag <= 1'b1;
      else if (error_clear_edge)
        warning_flag <= 1'b0; // [R06]
      if (bad_mode)
        setting_error <= 1'b1; // [R16]
      else if (error_clear_edge & (drive_power_state == st_fault))
        setting_error <= 1'b0; // [R05]
      if (int_error_s & (drive_power_state != st_not_ready))
        int_error_latched <= 1'b1;
      else if (error_clear_edge & (drive_power_state == st_fault))
        int_error_latched <= 1'b0; // [R05]
      if (power_lost)
        power_loss_latched <= 1'b1;
      else if (error_clear_edge)
        power_loss_latched <= 1'b0;
      main_power_on <= (next_drive_power_state == st_switched_on) |
                       (next_drive_power_state == st_run_enabled); // [R11]
      servo_on <= (next_drive_power_state == st_run_enabled); // [R11]
      // One-cycle stop strobes; the stop profile itself lives elsewhere
      stop_by_shutdown_option <= power_lost & ~undervolt_select & ~error_event; // [R12]
      stop_by_fault_option <= power_lost & undervolt_select & ~error_event; // [R13]
    end
  end

endmodule // drive_power_state_machine
`default_nettype wire

/* File: tb/drive_host_model.sv */
// Host controller model: APB master issuing commands and parameter accesses.
// Assumes pclk from the bench; one transfer at a time.
`timescale 1ns/10ps
`default_nettype none
module drive_host_model (
  input wire logic pclk,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [17:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0_0000;
    pwdata = 32'h0000_0000;
  end
  // Commands reach the drive only as command word writes
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output logic ok);
    int n;
    begin
      n = 0;
      ok = 1'b0;
      q = 32'h0000_0000;
      e = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer taken at the rising edge where pready is seen high; request held until then
      while (ok !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n++;
        ok = pready;
        q = prdata;
        e = pslverr;
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule // drive_host_model
`default_nettype wire

/* File: tb/drive_pds_sva.sv */
// Port checker for the drive power state machine.
// Bound to the design top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module drive_power_state_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic main_power_on,
  input wire logic servo_on,
  input wire logic stop_by_shutdown_option,
  input wire logic stop_by_fault_option
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    pready;
  endsequence
  property p_answer;
    s_setup |=> s_access;
  endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_single;
    pready |=> !pready;
  endproperty
  a_single: assert property (p_single) else $error("ready held too long");
  property p_idle_data;
    !pready |-> prdata == 32'h0000_0000 && !pslverr;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("data outside access");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_servo;
    servo_on |-> main_power_on;
  endproperty
  a_servo: assert property (p_servo) else $error("servo without main power");
  property p_through;
    $rose(servo_on) |-> $past(main_power_on);
  endproperty
  a_through: assert property (p_through) else $error("skipped switched on");
  property p_shut;
    stop_by_shutdown_option |-> !main_power_on && $past(servo_on);
  endproperty
  a_shut: assert property (p_shut) else $error("bad shutdown stop");
  property p_fault_stop;
    stop_by_fault_option |-> !main_power_on && $past(servo_on);
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("bad fault stop");
endmodule // drive_power_state_sva
bind drive_power_state_machine drive_power_state_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_power_on(main_power_on),
  .servo_on(servo_on), .stop_by_shutdown_option(stop_by_shutdown_option),
  .stop_by_fault_option(stop_by_fault_option));
`default_nettype wire

/* File: tb/drive_power_state_machine_tb.sv */
// Testbench for the drive power state machine.
// Host model drives APB; bench drives the status inputs.
`timescale 1ns/10ps
`default_nettype none
module drive_power_state_machine_tb;
  localparam logic [17:0] CW = 18'h1_8100;
  localparam logic [17:0] ST = 18'h1_8104;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic main_power_ok, init_done, internal_error, reaction_done, warning_in;
  logic main_power_on, servo_on, stop_by_shutdown_option, stop_by_fault_option, setting_error;
  logic [7:0] modes [5] = '{8'h01, 8'h06, 8'h08, 8'h09, 8'h0A};
  int error_cnt = 0;
  int n_tests = 0;
  drive_power_state_machine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_power_ok(main_power_ok), .init_done(init_done), .internal_error(internal_error),
    .reaction_done(reaction_done), .warning_in(warning_in), .main_power_on(main_power_on),
    .servo_on(servo_on), .stop_by_shutdown_option(stop_by_shutdown_option),
    .stop_by_fault_option(stop_by_fault_option), .setting_error(setting_error));
  drive_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task bus(input logic w, input logic [17:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(w, a, d, q, e, ok);
    chk({31'h0000_0000, ok}, 32'h0000_0001);
    if (ok !== 1'b1)
      stop_test;
  endtask
  task cw(input logic [15:0] c);
    bus(1'b1, CW, {16'h0000, c});
  endtask
  // Masks the live main power bit and the warning bit
  task st(input logic [31:0] exp);
    repeat (4) @(posedge pclk);
    bus(1'b0, ST, 32'h0000_0000);
    chk(q & 32'h0000_006F, exp);
  endtask
  task wait_pulse(input logic fault);
    int n;
    n = 0;
    while ((fault ? stop_by_fault_option : stop_by_shutdown_option) !== 1'b1 && n < 50)
    begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0000_0000, n < 50}, 32'h0000_0001);
    if (n >= 50)
      stop_test;
    // Hand back on a rising edge so later stimulus lands there
    @(posedge pclk);
  endtask
  task t_init;
    st(32'h0000_0000);
    init_done <= 1'b1;
    st(32'h0000_0060);
    bus(1'b0, 18'h1_9408, 32'h0000_0000);
    chk(q, 32'h0000_03A1);
    bus(1'b1, 18'h1_9408, 32'h0000_0000);
    chk(e, 1);
    bus(1'b0, 18'h0_0000, 32'h0000_0000);
    chk(e, 1);
    $display("init test done");
  endtask
  task t_power;
    cw(16'h0006);
    st(32'h0000_0021);
    cw(16'h000F);
    st(32'h0000_0027);
    @(negedge pclk);
    chk({servo_on, main_power_on}, 2'b11);
    cw(16'h000B);
    st(32'h0000_0027);
    cw(16'h0007);
    st(32'h0000_0023);
    @(negedge pclk);
    chk({servo_on, main_power_on}, 2'b01);
    cw(16'h0000);
    st(32'h0000_0060);
    cw(16'h000F);
    st(32'h0000_0060);
    $display("power test done");
  endtask
  task t_loss;
    bus(1'b1, 18'h0_D420, 32'h0000_0000);
    cw(16'h0006);
    cw(16'h000F);
    st(32'h0000_0027);
    main_power_ok <= 1'b0;
    wait_pulse(1'b0);
    cw(16'h0006);
    main_power_ok <= 1'b1;
    st(32'h0000_0021);
    bus(1'b1, 18'h0_D420, 32'h0000_0001);
    cw(16'h000F);
    st(32'h0000_0027);
    main_power_ok <= 1'b0;
    wait_pulse(1'b1);
    main_power_ok <= 1'b1;
    warning_in <= 1'b1;
    st(32'h0000_002F);
    reaction_done <= 1'b1;
    warning_in <= 1'b0;
    st(32'h0000_0028);
    chk(q & 32'h0000_0080, 32'h0000_0080);
    reaction_done <= 1'b0;
    cw(16'h0080);
    st(32'h0000_0060);
    chk(q & 32'h0000_0080, 32'h0000_0000);
    cw(16'h0000); // Host drops the clear bit before its next command
    $display("power loss test done");
  endtask
  task t_mode;
    foreach (modes[i])
    begin
      bus(1'b1, 18'h1_8180, {24'h00_0000, modes[i]});
      bus(1'b0, 18'h1_8184, 32'h0000_0000);
      chk(q, {24'h00_0000, modes[i]});
    end
    reaction_done <= 1'b1;
    bus(1'b1, 18'h1_8180, 32'h0000_0003);
    st(32'h0000_0028);
    chk(setting_error, 1);
    bus(1'b0, 18'h1_8184, 32'h0000_0000);
    chk(q, 32'h0000_000A);
    cw(16'h0080);
    st(32'h0000_0060);
    @(negedge pclk);
    chk(setting_error, 0);
    cw(16'h0000);
    internal_error <= 1'b1;
    st(32'h0000_0028);
    bus(1'b0, 18'h0_FFC0, 32'h0000_0000);
    chk(q, 32'h0000_0002);
    internal_error <= 1'b0;
    cw(16'h0080);
    st(32'h0000_0060);
    bus(1'b0, 18'h0_FFC0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    cw(16'h0000);
    $display("mode test done");
  endtask
  initial
  begin
    presetn = 1'b0;
    main_power_ok = 1'b1;
    init_done = 1'b0;
    internal_error = 1'b0;
    reaction_done = 1'b0;
    warning_in = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_init;
    t_power;
    t_loss;
    t_mode;
    stop_test;
  end
endmodule // drive_power_state_machine_tb
`default_nettype wire
